// ### src/tms_chan.v
// One compare output channel: holds the waveform level and applies the
// output action for the current mode family on each timer tick.
// Assumes match, bottom and direction flags are aligned to the same tick.
`timescale 1ns/1ps
`default_nettype none
`include "tms_map.vh"
module tms_chan #(
	parameter IS_A = 1'b1
) (
	input wire pclk,
	input wire presetn,
	input wire tick,
	input wire [1:0] action,
	input wire [1:0] mode_class,
	input wire toggle_ok,
	input wire match,
	input wire at_bottom,
	input wire count_up,
	input wire cmp_at_top,
	input wire cmp_at_bottom,
	output reg wave,
	output wire connected
);
	reg next_wave;
	wire may_toggle;

	// Toggle is legal always in non-PWM; in PWM modes only on channel A, and only where toggle_ok is set
	assign may_toggle = (mode_class == `TMS_CLS_NONPWM) | (toggle_ok & IS_A);
	assign connected = action[1] | (action[0] & may_toggle);

	// Next waveform level
	always @* begin
		next_wave = wave;
		if (tick) begin
			case (mode_class)
				`TMS_CLS_FAST: begin
					if (action[1]) begin
						if (at_bottom)
							next_wave = ~action[0];
						if (match & ~cmp_at_top)
							next_wave = action[0];
					end else if (action[0] & may_toggle & match) begin
						next_wave = ~wave;
					end
				end
				`TMS_CLS_DUAL: begin
					if (action[1]) begin
						if (cmp_at_bottom)
							next_wave = action[0];
						else if (cmp_at_top)
							next_wave = ~action[0];
						else if (match)
							next_wave = count_up ? action[0] : ~action[0];
					end else if (action[0] & may_toggle & match) begin
						next_wave = ~wave;
					end
				end
				default: begin
					if (match) begin
						case (action)
							`TMS_ACT_TOGGLE: next_wave = ~wave;
							`TMS_ACT_CLEAR: next_wave = 1'b0;
							`TMS_ACT_SET: next_wave = 1'b1;
							default: next_wave = wave;
						endcase
					end
				end
			endcase
		end
	end

	// Waveform register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wave <= 1'b0;
		else
			wave <= next_wave;
	end
endmodule
`default_nettype wire

// ### src/tms_map.vh
// Constants of the 16-bit timer output and mode select block: APB offsets,
// field positions, reset values and mode encodings.
// Assumes inclusion by bare name from the design files under src/.
`ifndef TMS_MAP_VH
`define TMS_MAP_VH

// ***************************************************************
// Register byte offsets (APB, one aligned word each)
// ***************************************************************
`define TMS_OFS_CTRL_A 8'h00
`define TMS_OFS_CTRL_B 8'h04
`define TMS_OFS_CMP_A 8'h08
`define TMS_OFS_CMP_B 8'h0c
`define TMS_OFS_CAPTURE 8'h10
`define TMS_OFS_COUNT 8'h14
`define TMS_OFS_PIN_DIR 8'h18
`define TMS_OFS_STATUS 8'h1c
`define TMS_OFS_INT_CLEAR 8'h20
`define TMS_OFS_INT_ENABLE 8'h24

// ***************************************************************
// Field positions
// ***************************************************************
`define TMS_CTRL_A_ACT_A_HI 7
`define TMS_CTRL_A_ACT_A_LO 6
`define TMS_CTRL_A_ACT_B_HI 5
`define TMS_CTRL_A_ACT_B_LO 4
`define TMS_CTRL_A_MODE_HI 1
`define TMS_CTRL_A_MODE_LO 0
`define TMS_CTRL_B_MODE_HI 4
`define TMS_CTRL_B_MODE_LO 3
`define TMS_CTRL_B_CS_HI 2
`define TMS_CTRL_B_CS_LO 0
`define TMS_CTRL_B_MASK 8'hdf
`define TMS_EV_OVF 0
`define TMS_EV_MATCH_A 1
`define TMS_EV_MATCH_B 2

// ***************************************************************
// Reset values
// ***************************************************************
`define TMS_RST_CTRL 8'h00
`define TMS_RST_WORD 16'h0000
`define TMS_RST_EV 3'h0
`define TMS_RST_DIR 2'h0

// ***************************************************************
// Mode families, event points and TOP sources
// ***************************************************************
`define TMS_CLS_NONPWM 2'h0
`define TMS_CLS_FAST 2'h1
`define TMS_CLS_DUAL 2'h2
`define TMS_PT_IMM 2'h0
`define TMS_PT_TOP 2'h1
`define TMS_PT_BOTTOM 2'h2
`define TMS_PT_MAX 2'h3
`define TMS_TOP_FIXED 2'h0
`define TMS_TOP_CAPTURE 2'h1
`define TMS_TOP_CMP_A 2'h2
`define TMS_TOP_8BIT 16'h00ff
`define TMS_TOP_9BIT 16'h01ff
`define TMS_TOP_10BIT 16'h03ff
`define TMS_TOP_MAX 16'hffff
`define TMS_BOTTOM 16'h0000
`define TMS_ACT_OFF 2'h0
`define TMS_ACT_TOGGLE 2'h1
`define TMS_ACT_CLEAR 2'h2
`define TMS_ACT_SET 2'h3

`endif

// ### src/tms_mode_dec.v
// Waveform mode decoder: maps the four-bit mode selector onto family,
// TOP source, compare reload point and overflow point.
// Assumes a purely combinational use inside the timer top.
`timescale 1ns/1ps
`default_nettype none
`include "tms_map.vh"
module tms_mode_dec (
	input wire [3:0] waveform_mode_select,
	output reg [1:0] mode_class,
	output reg [1:0] top_source,
	output reg [15:0] fixed_top,
	output reg [1:0] update_point,
	output reg [1:0] overflow_point,
	output reg toggle_ok
);
	// Decode of all sixteen mode codes
	always @* begin
		mode_class = `TMS_CLS_NONPWM;
		top_source = `TMS_TOP_FIXED;
		fixed_top = `TMS_TOP_MAX;
		update_point = `TMS_PT_IMM;
		overflow_point = `TMS_PT_MAX;
		toggle_ok = 1'b0;
		case (waveform_mode_select)
			4'h1, 4'h2, 4'h3, 4'ha, 4'hb: begin
				mode_class = `TMS_CLS_DUAL;
				update_point = `TMS_PT_TOP;
				overflow_point = `TMS_PT_BOTTOM;
			end
			4'h8, 4'h9: begin
				mode_class = `TMS_CLS_DUAL;
				update_point = `TMS_PT_BOTTOM;
				overflow_point = `TMS_PT_BOTTOM;
			end
			4'h5, 4'h6, 4'h7, 4'he, 4'hf: begin
				mode_class = `TMS_CLS_FAST;
				update_point = `TMS_PT_BOTTOM;
				overflow_point = `TMS_PT_TOP;
			end
			default: begin
				mode_class = `TMS_CLS_NONPWM;
			end
		endcase
		// TOP source and fixed resolutions
		case (waveform_mode_select)
			4'h1, 4'h5: fixed_top = `TMS_TOP_8BIT;
			4'h2, 4'h6: fixed_top = `TMS_TOP_9BIT;
			4'h3, 4'h7: fixed_top = `TMS_TOP_10BIT;
			4'h4, 4'h9, 4'hb, 4'hf: top_source = `TMS_TOP_CMP_A;
			4'h8, 4'ha, 4'hc, 4'he: top_source = `TMS_TOP_CAPTURE;
			default: fixed_top = `TMS_TOP_MAX;
		endcase
		// Toggle on channel A only in PWM modes 9, b, e and f
		case (waveform_mode_select)
			4'he, 4'hf: toggle_ok = 1'b1;
			4'h9, 4'hb: toggle_ok = 1'b1;
			default: toggle_ok = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ### src/tms_timer.v
// Top of the 16-bit timer output and mode select block: APB register file,
// counter sequence, compare reload, overflow and match flags, pin muxing.
// Assumes timer_tick is a one-cycle enable pulse from an external prescaler.
`timescale 1ns/1ps
`default_nettype none
`include "tms_map.vh"
module tms_timer (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire timer_tick,
	output reg wave_out_a,
	output reg wave_oe_a,
	output reg pin_override_a,
	output reg wave_out_b,
	output reg wave_oe_b,
	output reg pin_override_b,
	output reg irq
);
	// ***************************************************************
	// Declarations
	// ***************************************************************
	reg [7:0] timer_control_a;
	reg [7:0] timer_control_b;
	reg [15:0] cmp_a_buf;
	reg [15:0] cmp_b_buf;
	reg [15:0] compare_value_a;
	reg [15:0] compare_value_b;
	reg [15:0] capture_value;
	reg [15:0] count_value;
	reg count_up;
	reg [1:0] pin_dir;
	reg [2:0] status;
	reg [2:0] int_enable;
	reg [15:0] next_count;
	reg next_up;
	reg [31:0] next_prdata;
	reg next_slverr;
	reg next_ovf;
	reg [15:0] top;

	wire [3:0] waveform_mode_select;
	wire [1:0] chan_a_output_action;
	wire [1:0] chan_b_output_action;
	wire [1:0] mode_class;
	wire [1:0] top_source;
	wire [15:0] fixed_top;
	wire [1:0] update_point;
	wire [1:0] overflow_point;
	wire toggle_ok;
	wire setup;
	wire wr;
	wire tick;
	wire at_top;
	wire at_bottom;
	wire at_max;
	wire match_a;
	wire match_b;
	wire reload;
	wire [2:0] events;
	wire [2:0] clear_bits;
	wire wave_a;
	wire wave_b;
	wire conn_a;
	wire conn_b;

	// ***************************************************************
	// Field extraction
	// ***************************************************************
	// Mode selector joined from both control registers
	assign waveform_mode_select = {timer_control_b[`TMS_CTRL_B_MODE_HI:`TMS_CTRL_B_MODE_LO],
		timer_control_a[`TMS_CTRL_A_MODE_HI:`TMS_CTRL_A_MODE_LO]};
	assign chan_a_output_action = timer_control_a[`TMS_CTRL_A_ACT_A_HI:`TMS_CTRL_A_ACT_A_LO];
	assign chan_b_output_action = timer_control_a[`TMS_CTRL_A_ACT_B_HI:`TMS_CTRL_A_ACT_B_LO];

	// Bus phase decode; the slave never inserts wait states
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;

	// Counter runs only on ticks while a clock source is selected
	assign tick = timer_tick & (timer_control_b[`TMS_CTRL_B_CS_HI:`TMS_CTRL_B_CS_LO] != 3'h0);

	// ***************************************************************
	// Mode decoder
	// ***************************************************************
	tms_mode_dec u_dec (
		.waveform_mode_select(waveform_mode_select),
		.mode_class(mode_class),
		.top_source(top_source),
		.fixed_top(fixed_top),
		.update_point(update_point),
		.overflow_point(overflow_point),
		.toggle_ok(toggle_ok)
	);

	// TOP selection from fixed value, capture or active compare A
	always @* begin
		case (top_source)
			`TMS_TOP_CAPTURE: top = capture_value;
			`TMS_TOP_CMP_A: top = compare_value_a;
			default: top = fixed_top;
		endcase
	end

	// Counter position flags
	// Matches look at the count before the tick edge, so a TOP or BOTTOM
	// event and a compare match can fall on the same tick
	assign at_top = (count_value == top);
	assign at_bottom = (count_value == `TMS_BOTTOM);
	assign at_max = (count_value == `TMS_TOP_MAX);
	assign match_a = tick & (count_value == compare_value_a);
	assign match_b = tick & (count_value == compare_value_b);

	// ***************************************************************
	// Count sequence
	// ***************************************************************
	// Single slope wraps at TOP; dual slope turns round at TOP and BOTTOM
	always @* begin
		next_count = count_value;
		next_up = count_up;
		if (tick) begin
			if (mode_class == `TMS_CLS_DUAL) begin
				if (count_up & at_top) begin
					next_up = 1'b0;
					next_count = count_value - 16'h0001;
				end else if (~count_up & at_bottom) begin
					next_up = 1'b1;
					next_count = count_value + 16'h0001;
				end else begin
					next_count = count_up ? count_value + 16'h0001 : count_value - 16'h0001;
				end
			end else begin
				next_up = 1'b1;
				next_count = at_top ? `TMS_BOTTOM : count_value + 16'h0001;
			end
		end
	end

	// Counter register, software may also load it
	// A software load wins over a tick in the same cycle; the direction
	// bit is kept, so a dual-slope count carries on along its slope
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_value <= `TMS_RST_WORD;
			count_up <= 1'b1;
		end else if (wr && paddr == `TMS_OFS_COUNT) begin
			count_value <= pwdata[15:0];
		end else begin
			count_value <= next_count;
			count_up <= next_up;
		end
	end

	// ***************************************************************
	// Compare reload and overflow
	// ***************************************************************
	// Buffered compare values move to the active copies at the reload point
	// Immediate modes copy every cycle, so the active value trails a
	// buffer write by one clock only
	assign reload = (update_point == `TMS_PT_IMM) |
		(tick & (update_point == `TMS_PT_TOP) & at_top) |
		(tick & (update_point == `TMS_PT_BOTTOM) & at_bottom);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_value_a <= `TMS_RST_WORD;
			compare_value_b <= `TMS_RST_WORD;
		end else if (reload) begin
			compare_value_a <= cmp_a_buf;
			compare_value_b <= cmp_b_buf;
		end
	end

	// Overflow point per mode family
	always @* begin
		case (overflow_point)
			`TMS_PT_TOP: next_ovf = tick & at_top;
			`TMS_PT_BOTTOM: next_ovf = tick & at_bottom & ~count_up;
			default: next_ovf = tick & at_max;
		endcase
	end

	assign events = {match_b, match_a, next_ovf};
	assign clear_bits = (wr && paddr == `TMS_OFS_INT_CLEAR) ? pwdata[2:0] : 3'h0;

	// ***************************************************************
	// Output channels
	// ***************************************************************
	tms_chan #(.IS_A(1'b1)) u_chan_a (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.action(chan_a_output_action),
		.mode_class(mode_class),
		.toggle_ok(toggle_ok),
		.match(match_a),
		.at_bottom(at_bottom),
		.count_up(count_up),
		.cmp_at_top(compare_value_a == top),
		.cmp_at_bottom(compare_value_a == `TMS_BOTTOM),
		.wave(wave_a),
		.connected(conn_a)
	);

	tms_chan #(.IS_A(1'b0)) u_chan_b (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.action(chan_b_output_action),
		.mode_class(mode_class),
		.toggle_ok(toggle_ok),
		.match(match_b),
		.at_bottom(at_bottom),
		.count_up(count_up),
		.cmp_at_top(compare_value_b == top),
		.cmp_at_bottom(compare_value_b == `TMS_BOTTOM),
		.wave(wave_b),
		.connected(conn_b)
	);

	// Pin mux: waveform takes the pin, driver needs the direction bit too
	// The claim follows the action field even while the driver stays off,
	// so the port logic can tell a parked pin from a free one
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_out_a <= 1'b0;
			wave_oe_a <= 1'b0;
			pin_override_a <= 1'b0;
			wave_out_b <= 1'b0;
			wave_oe_b <= 1'b0;
			pin_override_b <= 1'b0;
		end else begin
			wave_out_a <= wave_a;
			pin_override_a <= conn_a;
			wave_oe_a <= conn_a & pin_dir[0];
			wave_out_b <= wave_b;
			pin_override_b <= conn_b;
			wave_oe_b <= conn_b & pin_dir[1];
		end
	end

	// ***************************************************************
	// Register writes
	// ***************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_a <= `TMS_RST_CTRL;
			timer_control_b <= `TMS_RST_CTRL;
			cmp_a_buf <= `TMS_RST_WORD;
			cmp_b_buf <= `TMS_RST_WORD;
			capture_value <= `TMS_RST_WORD;
			pin_dir <= `TMS_RST_DIR;
			int_enable <= `TMS_RST_EV;
		end else if (wr) begin
			case (paddr)
				`TMS_OFS_CTRL_A: timer_control_a <= pwdata[7:0];
				`TMS_OFS_CTRL_B: timer_control_b <= pwdata[7:0] & `TMS_CTRL_B_MASK;
				`TMS_OFS_CMP_A: cmp_a_buf <= pwdata[15:0];
				`TMS_OFS_CMP_B: cmp_b_buf <= pwdata[15:0];
				`TMS_OFS_CAPTURE: capture_value <= pwdata[15:0];
				`TMS_OFS_PIN_DIR: pin_dir <= pwdata[1:0];
				`TMS_OFS_INT_ENABLE: int_enable <= pwdata[2:0];
				default: int_enable <= int_enable;
			endcase
		end
	end

	// Sticky event flags; a new event wins over a clear in the same cycle
	// Writes to the status offset are ignored; only the clear register
	// takes flags down
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status <= `TMS_RST_EV;
		else
			status <= (status & ~clear_bits) | events;
	end

	// Level interrupt from enabled flags
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(((status & ~clear_bits) | events) & int_enable);
	end

	// ***************************************************************
	// Register reads
	// ***************************************************************
	// Read data is captured in the setup cycle and held through access
	// A write transfer returns zero read data; the error flag is raised
	// for an unmapped offset in either direction
	always @* begin
		next_prdata = 32'h00000000;
		next_slverr = 1'b0;
		case (paddr)
			`TMS_OFS_CTRL_A: next_prdata = {24'h000000, timer_control_a};
			`TMS_OFS_CTRL_B: next_prdata = {24'h000000, timer_control_b};
			`TMS_OFS_CMP_A: next_prdata = {16'h0000, cmp_a_buf};
			`TMS_OFS_CMP_B: next_prdata = {16'h0000, cmp_b_buf};
			`TMS_OFS_CAPTURE: next_prdata = {16'h0000, capture_value};
			`TMS_OFS_COUNT: next_prdata = {16'h0000, count_value};
			`TMS_OFS_PIN_DIR: next_prdata = {30'h00000000, pin_dir};
			`TMS_OFS_STATUS: next_prdata = {29'h00000000, status};
			`TMS_OFS_INT_CLEAR: next_prdata = 32'h00000000;
			`TMS_OFS_INT_ENABLE: next_prdata = {29'h00000000, int_enable};
			default: next_slverr = 1'b1;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup) begin
				prdata <= pwrite ? 32'h00000000 : next_prdata;
				pslverr <= next_slverr;
			end
		end
	end
endmodule
`default_nettype wire

// ### test/tms_pin_model.sv
// Port pin model for one waveform channel.
// Assumes a pull-up on the pin while its driver is off.
`timescale 1ns/1ps
`default_nettype none
module tms_pin_model (
	input wire logic oe,
	input wire logic wave,
	output wire logic pin
);
	// Driven pin follows the wave, released pin goes to the pull-up
	assign pin = oe ? wave : 1'b1;
endmodule
`default_nettype wire

// ### test/tms_timer_monitor.sv
// Concurrent checks on the ports of the timer output and mode select block.
// Assumes one pclk domain, reset presetn asynchronous active low.
`timescale 1ns/1ps
`default_nettype none
`include "tms_map.vh"
module tms_timer_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic timer_tick,
	input wire logic wave_out_a,
	input wire logic wave_oe_a,
	input wire logic pin_override_a,
	input wire logic wave_oe_b,
	input wire logic pin_override_b,
	input wire logic irq
);
	// ***************************************************************
	// Helpers
	// ***************************************************************
	default clocking mon_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Completed writes to the action field and to the interrupt registers
	wire logic wr_ctl = psel & penable & pwrite & (paddr == `TMS_OFS_CTRL_A);
	wire logic wr_int = psel & penable & pwrite & ((paddr == `TMS_OFS_INT_CLEAR) | (paddr == `TMS_OFS_INT_ENABLE));

	// ***************************************************************
	// Assertions
	// ***************************************************************
	a_oe_a_claimed: assert property (wave_oe_a |-> pin_override_a)
		else $error("driver a on without pin claim");
	a_oe_b_claimed: assert property (wave_oe_b |-> pin_override_b)
		else $error("driver b on without pin claim");
	a_claim_a_on: assert property (wr_ctl && pwdata[7] |-> ##[1:2] pin_override_a)
		else $error("pin a not claimed");
	a_claim_a_off: assert property (wr_ctl && pwdata[7:6] == 2'h0 |-> ##[1:2] !pin_override_a)
		else $error("pin a still claimed");
	a_claim_b_on: assert property (wr_ctl && pwdata[5] |-> ##[1:2] pin_override_b)
		else $error("pin b not claimed");
	a_claim_b_off: assert property (wr_ctl && pwdata[5:4] == 2'h0 |-> ##[1:2] !pin_override_b)
		else $error("pin b still claimed");
	a_err_unmapped: assert property (psel && !penable && !pwrite && paddr > `TMS_OFS_INT_ENABLE
		|=> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	a_wave_on_tick: assert property ($changed(wave_out_a) |-> $past(timer_tick, 2))
		else $error("wave a moved without a tick");
	a_irq_fall_cause: assert property ($fell(irq) |-> $past(wr_int) || $past(wr_int, 2))
		else $error("irq dropped without clear or mask");
	a_ready_held: assert property (pready |=> pready)
		else $error("pready dropped");
endmodule
bind tms_timer tms_timer_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.timer_tick(timer_tick), .wave_out_a(wave_out_a), .wave_oe_a(wave_oe_a), .pin_override_a(pin_override_a),
	.wave_oe_b(wave_oe_b), .pin_override_b(pin_override_b), .irq(irq));
`default_nettype wire

// ### test/tms_timer_tb_top.sv
// Self-checking bench for the timer output and mode select block.
// Assumes the design files and tms_map.vh are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "tms_map.vh"
module tms_timer_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic timer_tick = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd;
	logic re;
	wire [31:0] prdata;
	wire pready, pslverr, irq, pin_a, pin_b;
	wire wave_out_a, wave_oe_a, pin_override_a, wave_out_b, wave_oe_b, pin_override_b;
	int err_total = 0;
	int tests_run = 0;

	// Clock, 20 ns period
	always #10 pclk = ~pclk;

	tms_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_tick(timer_tick), .wave_out_a(wave_out_a), .wave_oe_a(wave_oe_a),
		.pin_override_a(pin_override_a), .wave_out_b(wave_out_b), .wave_oe_b(wave_oe_b),
		.pin_override_b(pin_override_b), .irq(irq));
	tms_pin_model u_pin_a (.oe(wave_oe_a), .wave(wave_out_a), .pin(pin_a));
	tms_pin_model u_pin_b (.oe(wave_oe_b), .wave(wave_out_b), .pin(pin_b));

	// ***************************************************************
	// Shared tasks
	// ***************************************************************
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_total++;
			print_verdict;
		end
	endtask

	task automatic settle;
		repeat (2) @(posedge pclk);
	endtask

	// Runs n back-to-back timer ticks, then lets the outputs land
	task automatic ticks(input int n);
		@(posedge pclk);
		timer_tick <= 1'b1;
		repeat (n) @(posedge pclk);
		timer_tick <= 1'b0;
		settle;
	endtask

	// ***************************************************************
	// Scenarios
	// ***************************************************************
	task automatic t_regs;
		apb(1'b0, `TMS_OFS_CTRL_A, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, `TMS_OFS_CTRL_B, 32'hff);
		apb(1'b0, `TMS_OFS_CTRL_B, 32'h0);
		chk(rd, 32'hdf);
		apb(1'b1, `TMS_OFS_CTRL_B, 32'h0);
		apb(1'b1, `TMS_OFS_STATUS, 32'h7);
		apb(1'b0, `TMS_OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk(re, 32'h1);
		chk(rd, 32'h0);
	endtask

	task automatic t_normal;
		apb(1'b1, `TMS_OFS_PIN_DIR, 32'h3);
		apb(1'b1, `TMS_OFS_CMP_A, 32'h3);
		apb(1'b1, `TMS_OFS_CMP_B, 32'h2);
		apb(1'b1, `TMS_OFS_CTRL_A, 32'h70);
		apb(1'b1, `TMS_OFS_CTRL_B, 32'h1);
		settle;
		chk(pin_override_a, 32'h1);
		chk(pin_override_b, 32'h1);
		chk(wave_oe_a, 32'h1);
		chk(wave_oe_b, 32'h1);
		ticks(5);
		chk(wave_out_a, 32'h1);
		chk(wave_out_b, 32'h1);
		apb(1'b1, `TMS_OFS_CTRL_A, 32'ha0);
		apb(1'b1, `TMS_OFS_COUNT, 32'hfffe);
		apb(1'b1, `TMS_OFS_INT_CLEAR, 32'h7);
		ticks(2);
		apb(1'b0, `TMS_OFS_STATUS, 32'h0);
		chk(rd, 32'h1);
		ticks(4);
		chk(wave_out_a, 32'h0);
		chk(wave_out_b, 32'h0);
		apb(1'b0, `TMS_OFS_COUNT, 32'h0);
		chk(rd, 32'h4);
		apb(1'b1, `TMS_OFS_INT_ENABLE, 32'h1);
		settle;
		chk(irq, 32'h1);
		apb(1'b1, `TMS_OFS_INT_ENABLE, 32'h0);
		settle;
		chk(irq, 32'h0);
		apb(1'b1, `TMS_OFS_INT_ENABLE, 32'h1);
		apb(1'b1, `TMS_OFS_INT_CLEAR, 32'h1);
		settle;
		chk(irq, 32'h0);
		apb(1'b0, `TMS_OFS_STATUS, 32'h0);
		chk(rd, 32'h6);
		apb(1'b1, `TMS_OFS_PIN_DIR, 32'h0);
		settle;
		chk(wave_oe_a, 32'h0);
		chk(pin_a, 32'h1);
		chk(pin_b, 32'h1);
		apb(1'b1, `TMS_OFS_PIN_DIR, 32'h3);
		settle;
		chk(pin_a, 32'h0);
		apb(1'b1, `TMS_OFS_CTRL_A, 32'h0);
		settle;
		chk(pin_override_a, 32'h0);
		chk(pin_override_b, 32'h0);
		apb(1'b1, `TMS_OFS_CTRL_B, 32'h9);
		apb(1'b1, `TMS_OFS_COUNT, 32'h0);
		ticks(6);
		apb(1'b0, `TMS_OFS_COUNT, 32'h0);
		chk(rd, 32'h2);
	endtask

	task automatic t_fast;
		apb(1'b1, `TMS_OFS_CTRL_A, 32'h51);
		settle;
		chk({pin_override_a, pin_override_b}, 32'h0);
		apb(1'b1, `TMS_OFS_CTRL_A, 32'h53);
		apb(1'b1, `TMS_OFS_CTRL_B, 32'h19);
		settle;
		chk({pin_override_a, pin_override_b}, 32'h2);
		apb(1'b1, `TMS_OFS_CTRL_B, 32'h9);
		apb(1'b1, `TMS_OFS_CTRL_A, 32'hb1);
		apb(1'b1, `TMS_OFS_CMP_A, 32'h10);
		apb(1'b1, `TMS_OFS_CMP_B, 32'h20);
		apb(1'b1, `TMS_OFS_COUNT, 32'hfe);
		apb(1'b1, `TMS_OFS_INT_CLEAR, 32'h7);
		ticks(2);
		apb(1'b0, `TMS_OFS_STATUS, 32'h0);
		chk(rd[0], 32'h1);
		apb(1'b0, `TMS_OFS_COUNT, 32'h0);
		chk(rd, 32'h0);
		ticks(1);
		chk(wave_out_a, 32'h1);
		chk(wave_out_b, 32'h0);
		ticks(16);
		chk(wave_out_a, 32'h0);
		ticks(16);
		chk(wave_out_b, 32'h1);
	endtask

	task automatic t_dual;
		apb(1'b1, `TMS_OFS_CTRL_B, 32'h1);
		apb(1'b1, `TMS_OFS_CTRL_A, 32'hb1);
		apb(1'b1, `TMS_OFS_CMP_A, 32'h40);
		apb(1'b1, `TMS_OFS_CMP_B, 32'h40);
		apb(1'b1, `TMS_OFS_COUNT, 32'h0);
		ticks(256);
		apb(1'b1, `TMS_OFS_INT_CLEAR, 32'h7);
		ticks(191);
		chk(wave_out_a, 32'h1);
		chk(wave_out_b, 32'h0);
		ticks(128);
		chk(wave_out_a, 32'h0);
		chk(wave_out_b, 32'h1);
		apb(1'b0, `TMS_OFS_STATUS, 32'h0);
		chk(rd[0], 32'h1);
		apb(1'b1, `TMS_OFS_CMP_A, 32'hff);
		apb(1'b1, `TMS_OFS_CMP_B, 32'hff);
		ticks(223);
		chk(wave_out_a, 32'h1);
		chk(wave_out_b, 32'h0);
	endtask

	// Compare at TOP in fast mode, toggle in modes 11 and 10, overflow in mode 9
	task automatic t_edge;
		apb(1'b1, `TMS_OFS_CTRL_B, 32'h9);
		apb(1'b1, `TMS_OFS_COUNT, 32'hfe);
		ticks(2);
		chk(wave_out_a, 32'h1);
		chk(wave_out_b, 32'h0);
		apb(1'b1, `TMS_OFS_CTRL_A, 32'h53);
		apb(1'b1, `TMS_OFS_CTRL_B, 32'h11);
		settle;
		chk({pin_override_a, pin_override_b}, 32'h2);
		apb(1'b1, `TMS_OFS_COUNT, 32'hfe);
		ticks(2);
		chk(wave_out_a, 32'h0);
		apb(1'b1, `TMS_OFS_CTRL_A, 32'h52);
		settle;
		chk({pin_override_a, pin_override_b}, 32'h0);
		apb(1'b1, `TMS_OFS_CTRL_A, 32'h51);
		apb(1'b1, `TMS_OFS_COUNT, 32'h1);
		apb(1'b1, `TMS_OFS_INT_CLEAR, 32'h7);
		ticks(2);
		apb(1'b0, `TMS_OFS_STATUS, 32'h0);
		chk(rd, 32'h1);
	endtask

	// Main sequence; the reserved mode code is never programmed
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_normal;
		t_fast;
		t_dual;
		t_edge;
		print_verdict;
	end
endmodule
`default_nettype wire
